// File: rtl/tcio_pkg.sv
// Package: register map, field layout and reset values of the timer channel I/O block
// What this block does
// RQ1 - Compare action 00 disables pin output, 01 drives low; field bit 2 sets initial level
// RQ2 - Compare action 10 drives the pin high on every compare match
// RQ3 - Compare action 11 inverts the pin on every compare match
// RQ4 - Field bit 3 set selects capture from own pin; code 00 captures rising edges
// RQ5 - Capture code 01 latches the counter on falling edges; bit 2 is ignored
// RQ6 - Capture with bit 1 set uses both edges; bits 3..0 are A, 7..4 are B
// RQ7 - Enable bit 0 gates the register A compare/capture request
// RQ8 - Enable bit 1 gates the register B compare/capture request
// RQ9 - Enable bits 4 and 5 gate the overflow and underflow requests
// RQ10 - Enable bit 7 permits converter start requests; clear means none
// RQ11 - Register A flag sets on compare match or on capture into register A
// RQ12 - Overflow flag sets on wrap ffff to 0; underflow on 0 to ffff
// RQ13 - Enable bits gate only the requests; flags are set regardless
package tcio_pkg;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam int unsigned TCIO_AW = 18;
  localparam logic [15:0] TCIO_IDX_PFC = 16'hfff2;
  localparam logic [15:0] TCIO_IDX_CTL = 16'hfff3;
  localparam logic [15:0] TCIO_IDX_IEN = 16'hfff4;
  localparam logic [15:0] TCIO_IDX_STAT = 16'hfff5;
  localparam logic [15:0] TCIO_IDX_CNT = 16'hfff6;
  localparam logic [15:0] TCIO_IDX_GRA = 16'hfff8;
  localparam logic [15:0] TCIO_IDX_GRB = 16'hfffa;
  localparam logic [17:0] TCIO_ADDR_PFC = {TCIO_IDX_PFC, 2'b00};
  localparam logic [17:0] TCIO_ADDR_CTL = {TCIO_IDX_CTL, 2'b00};
  localparam logic [17:0] TCIO_ADDR_IEN = {TCIO_IDX_IEN, 2'b00};
  localparam logic [17:0] TCIO_ADDR_STAT = {TCIO_IDX_STAT, 2'b00};
  localparam logic [17:0] TCIO_ADDR_CNT = {TCIO_IDX_CNT, 2'b00};
  localparam logic [17:0] TCIO_ADDR_GRA = {TCIO_IDX_GRA, 2'b00};
  localparam logic [17:0] TCIO_ADDR_GRB = {TCIO_IDX_GRB, 2'b00};

  // ==========================================================================
  // Field positions
  localparam int unsigned FLD_CAPTURE = 3;
  localparam int unsigned FLD_INIT = 2;
  localparam int unsigned FLD_W = 4;
  localparam int unsigned BIT_A = 0;
  localparam int unsigned BIT_B = 1;
  localparam int unsigned BIT_OVF = 4;
  localparam int unsigned BIT_UNF = 5;
  localparam int unsigned BIT_TRG = 7;
  localparam int unsigned CTL_RUN = 0;
  localparam int unsigned CTL_DOWN = 1;
  localparam logic [7:0] IEN_MASK = 8'hb3;
  localparam logic [7:0] STAT_MASK = 8'h33;
  localparam logic [7:0] CTL_MASK = 8'h03;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] PFC_RST = 8'h00;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] GR_RST = 16'hffff;

  typedef enum logic [1:0] {
    ACT_OFF = 2'b00,
    ACT_LOW = 2'b01,
    ACT_HIGH = 2'b10,
    ACT_TOGGLE = 2'b11
  } tcio_action_t;

endpackage

// File: rtl/tcio_sync.sv
// Pin synchroniser with rising and falling edge detection
`timescale 1ns/10ps
module tcio_sync
  import tcio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_i,
  output logic rise,
  output logic fall
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // ==========================================================================
  // Two flops before use; edges seen only on stable stages
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;

endmodule // tcio_sync

// File: rtl/tcio_chan.sv
// One general register with its compare output and capture input
`timescale 1ns/10ps
module tcio_chan
  import tcio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] field,
  input wire logic gr_wr,
  input wire logic [15:0] gr_wdata,
  input wire logic [15:0] count,
  input wire logic count_run,
  input wire logic rise,
  input wire logic fall,
  output logic [15:0] gr_q,
  output logic pin_o_q,
  output logic pin_oe_q,
  output logic event_q
);

  logic [3:0] field_prev_q;
  logic capture;
  logic match;
  logic cap_hit;
  tcio_action_t act;

  assign capture = field[FLD_CAPTURE];
  assign act = tcio_action_t'(field[1:0]);
  // A stopped counter gives no repeated matches
  assign match = ~capture & count_run & (count == gr_q);
  // Bit 2 plays no part in capture
  assign cap_hit = capture & (field[1] ? (rise | fall) : (field[0] ? fall : rise)); // RQ4 RQ5 RQ6

  // ==========================================================================
  // General register; capture wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gr_q <= GR_RST;
    else if (cap_hit)
      gr_q <= count; // RQ4
    else if (gr_wr)
      gr_q <= gr_wdata;
  end

  // ==========================================================================
  // Pin output; new field reloads the initial level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      field_prev_q <= PFC_RST[3:0];
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end
    else
    begin
      field_prev_q <= field;
      pin_oe_q <= ~capture & (act != ACT_OFF); // RQ1
      if (field != field_prev_q)
        pin_o_q <= field[FLD_INIT]; // RQ1
      else if (match)
      begin
        case (act)
          ACT_LOW: pin_o_q <= 1'b0; // RQ1
          ACT_HIGH: pin_o_q <= 1'b1; // RQ2
          ACT_TOGGLE: pin_o_q <= ~pin_o_q; // RQ3
          default: pin_o_q <= pin_o_q;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_q <= 1'b0;
    else
      event_q <= match | cap_hit; // RQ11
  end

endmodule // tcio_chan

// File: rtl/tcio_top.sv
// Timer channel pin function and interrupt request control with APB access
`timescale 1ns/10ps
module tcio_top
  import tcio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [TCIO_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pin_a_i,
  output logic pin_a_o,
  output logic pin_a_oe,
  input wire logic pin_b_i,
  output logic pin_b_o,
  output logic pin_b_oe,
  output logic match_a_irq,
  output logic match_b_irq,
  output logic overflow_irq,
  output logic underflow_irq,
  output logic converter_start
);

  logic [7:0] pfc_q;
  logic [7:0] ien_q;
  logic [7:0] ctl_q;
  logic [7:0] stat_q;
  logic [7:0] stat_d;
  logic [15:0] cnt_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic setup;
  logic wr_en;
  logic [31:0] rd_d;
  logic hit_d;
  logic run;
  logic ovf_evt;
  logic unf_evt;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic [1:0] pin_i_w;
  logic [1:0] rise_w;
  logic [1:0] fall_w;
  logic [1:0] gr_wr_w;
  logic [15:0] gr_w [2];
  logic [1:0] pin_o_w;
  logic [1:0] pin_oe_w;
  logic [1:0] ev_w;
  logic match_a_irq_q;
  logic match_b_irq_q;
  logic overflow_irq_q;
  logic underflow_irq_q;
  logic converter_start_q;

  // ==========================================================================
  // APB slave: one wait-free access phase, read data from a flop
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    hit_d = 1'b1;
    if (paddr == TCIO_ADDR_PFC)
      rd_d = {24'h00_0000, pfc_q};
    else if (paddr == TCIO_ADDR_CTL)
      rd_d = {24'h00_0000, ctl_q};
    else if (paddr == TCIO_ADDR_IEN)
      rd_d = {24'h00_0000, ien_q};
    else if (paddr == TCIO_ADDR_STAT)
      rd_d = {24'h00_0000, stat_q};
    else if (paddr == TCIO_ADDR_CNT)
      rd_d = {16'h0000, cnt_q};
    else if (paddr == TCIO_ADDR_GRA)
      rd_d = {16'h0000, gr_w[0]};
    else if (paddr == TCIO_ADDR_GRB)
      rd_d = {16'h0000, gr_w[1]};
    else
      hit_d = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= setup;
      if (setup)
      begin
        pslverr_q <= ~hit_d;
        prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      end
    end
  end

  // ==========================================================================
  // Software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pfc_q <= PFC_RST;
      ien_q <= IEN_RST;
      ctl_q <= CTL_RST;
    end
    else if (wr_en)
    begin
      if (paddr == TCIO_ADDR_PFC)
        pfc_q <= pwdata[7:0];
      else if (paddr == TCIO_ADDR_IEN)
        ien_q <= pwdata[7:0] & IEN_MASK;
      else if (paddr == TCIO_ADDR_CTL)
        ctl_q <= pwdata[7:0] & CTL_MASK;
    end
  end

  assign gr_wr_w[0] = wr_en & (paddr == TCIO_ADDR_GRA);
  assign gr_wr_w[1] = wr_en & (paddr == TCIO_ADDR_GRB);

  // ==========================================================================
  // Counter with wrap detection
  assign run = ctl_q[CTL_RUN];
  assign ovf_evt = run & ~ctl_q[CTL_DOWN] & (cnt_q == CNT_MAX); // RQ12
  assign unf_evt = run & ctl_q[CTL_DOWN] & (cnt_q == CNT_RST); // RQ12

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= CNT_RST;
    else if (wr_en && paddr == TCIO_ADDR_CNT)
      cnt_q <= pwdata[15:0];
    else if (run)
      cnt_q <= ctl_q[CTL_DOWN] ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
  end

  // ==========================================================================
  // Channels: bits 3..0 drive A, bits 7..4 drive B
  assign pin_i_w = {pin_b_i, pin_a_i};

  for (genvar g = 0; g < 2; g++)
  begin : g_chan
    tcio_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_i(pin_i_w[g]),
      .rise(rise_w[g]),
      .fall(fall_w[g])
    );
    tcio_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .field(pfc_q[g*FLD_W +: FLD_W]), // RQ6
      .gr_wr(gr_wr_w[g]),
      .gr_wdata(pwdata[15:0]),
      .count(cnt_q),
      .count_run(run),
      .rise(rise_w[g]),
      .fall(fall_w[g]),
      .gr_q(gr_w[g]),
      .pin_o_q(pin_o_w[g]),
      .pin_oe_q(pin_oe_w[g]),
      .event_q(ev_w[g])
    );
  end

  // ==========================================================================
  // Status flags: write 0 clears, a same-cycle event wins
  always_comb
  begin
    set_v = 8'h00;
    set_v[BIT_A] = ev_w[0]; // RQ11
    set_v[BIT_B] = ev_w[1];
    set_v[BIT_OVF] = ovf_evt; // RQ12
    set_v[BIT_UNF] = unf_evt;
    clr_v = 8'h00;
    if (wr_en && paddr == TCIO_ADDR_STAT)
      clr_v = ~pwdata[7:0] & STAT_MASK;
    stat_d = (stat_q & ~clr_v) | set_v; // RQ13
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_q <= STAT_RST;
    else
      stat_q <= stat_d;
  end

  // ==========================================================================
  // Request gating; flags stay visible whatever the enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      match_a_irq_q <= 1'b0;
      match_b_irq_q <= 1'b0;
      overflow_irq_q <= 1'b0;
      underflow_irq_q <= 1'b0;
      converter_start_q <= 1'b0;
    end
    else
    begin
      match_a_irq_q <= stat_q[BIT_A] & ien_q[BIT_A]; // RQ7
      match_b_irq_q <= stat_q[BIT_B] & ien_q[BIT_B]; // RQ8
      overflow_irq_q <= stat_q[BIT_OVF] & ien_q[BIT_OVF]; // RQ9
      underflow_irq_q <= stat_q[BIT_UNF] & ien_q[BIT_UNF]; // RQ9
      converter_start_q <= ev_w[0] & ien_q[BIT_TRG]; // RQ10
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pin_a_o = pin_o_w[0];
  assign pin_a_oe = pin_oe_w[0];
  assign pin_b_o = pin_o_w[1];
  assign pin_b_oe = pin_oe_w[1];
  assign match_a_irq = match_a_irq_q;
  assign match_b_irq = match_b_irq_q;
  assign overflow_irq = overflow_irq_q;
  assign underflow_irq = underflow_irq_q;
  assign converter_start = converter_start_q;

  // ==========================================================================
  // Assertions: pin outputs
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  act_low_a: assert property ( // RQ1
    ev_w[0] && !pfc_q[3] && pfc_q[1:0] == 2'b01 && $stable(pfc_q[3:0]) |-> !pin_a_o)
    else $error("pin A not low after match");
  oe_off_a: assert property ( // RQ1
    pfc_q[3:0] == 4'b0100 |=> !pin_a_oe)
    else $error("pin A enabled with action off");
  act_high_b_a: assert property ( // RQ2
    ev_w[1] && pfc_q[7:4] == 4'b0010 && $stable(pfc_q[7:4]) |-> pin_b_o)
    else $error("pin B not high after match");
  toggle_a_a: assert property ( // RQ3
    ev_w[0] && pfc_q[3:0] == 4'b0111 && $stable(pfc_q[3:0]) |-> pin_a_o != $past(pin_a_o))
    else $error("pin A did not toggle");
  cap_oe_a: assert property ( // RQ4
    pfc_q[FLD_CAPTURE] |=> !pin_a_oe)
    else $error("pin A driven in capture mode");

  // ==========================================================================
  // Assertions: capture and flags
  cap_rise_a: assert property ( // RQ4
    pfc_q[3:0] == 4'b1000 && rise_w[0] |=> gr_w[0] == $past(cnt_q) && ev_w[0])
    else $error("rising capture missed");
  cap_fall_a: assert property ( // RQ5
    pfc_q[7:4] == 4'b1101 && fall_w[1] |=> gr_w[1] == $past(cnt_q) && ev_w[1])
    else $error("falling capture missed");
  cap_both_a: assert property ( // RQ6
    pfc_q[3] && pfc_q[1] && (rise_w[0] || fall_w[0]) |=> ev_w[0] ##1 stat_q[BIT_A])
    else $error("both edge capture missed");
  flag_set_a: assert property ( // RQ11 RQ13
    ev_w[0] |=> stat_q[BIT_A])
    else $error("A flag lost on set");
  unf_flag_a: assert property ( // RQ12 RQ13
    unf_evt |=> stat_q[BIT_UNF])
    else $error("underflow flag lost on set");

  // ==========================================================================
  // Assertions: request gating
  gate_ab_a: assert property ( // RQ7 RQ8
    (stat_q[BIT_A] && !ien_q[BIT_A] |=> !match_a_irq)
    and (stat_q[BIT_B] && ien_q[BIT_B] |=> match_b_irq))
    else $error("match request gating wrong");
  gate_ovf_a: assert property ( // RQ9 RQ12 RQ13
    ovf_evt && !ien_q[BIT_OVF]
    |=> stat_q[BIT_OVF] && cnt_q == CNT_RST ##1 !overflow_irq)
    else $error("overflow flag or gating wrong");
  unf_wrap_a: assert property ( // RQ9 RQ12
    unf_evt && ien_q[BIT_UNF]
    |=> stat_q[BIT_UNF] && cnt_q == CNT_MAX ##1 underflow_irq)
    else $error("underflow flag or request wrong");
  ovf_req_a: assert property ( // RQ9
    stat_q[BIT_OVF] && ien_q[BIT_OVF] |=> overflow_irq)
    else $error("overflow request missing");
  unf_gate_a: assert property ( // RQ9
    stat_q[BIT_UNF] && !ien_q[BIT_UNF] |=> !underflow_irq)
    else $error("underflow request not blocked");
  trig_gate_a: assert property ( // RQ10
    ev_w[0] |=> converter_start == $past(ien_q[BIT_TRG]))
    else $error("converter start gating wrong");
  no_trig_a: assert property ( // RQ10
    !ien_q[BIT_TRG] |=> !converter_start)
    else $error("converter start while disabled");

  // ==========================================================================
  // Covers of the main scenarios
  toggle_c: cover property (ev_w[0] && pfc_q[1:0] == 2'b11 && !pfc_q[3]);
  capture_c: cover property (pfc_q[7] && ev_w[1]);
  overflow_c: cover property (ovf_evt ##1 stat_q[BIT_OVF] ##1 overflow_irq);
  underflow_c: cover property (unf_evt ##1 stat_q[BIT_UNF] ##1 underflow_irq);
  set_clr_c: cover property (ev_w[0] && wr_en && paddr == TCIO_ADDR_STAT && !pwdata[0]);

endmodule // tcio_top

// File: dv/tcio_pin_model.sv
// Partner model: far-side driver of one timer channel pin
`timescale 1ns/10ps
module tcio_pin_model
(
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic ext_lvl,
  output logic pin_i
);
  // ==========================================
  // Wire level
  // Block drives while enabled, else the far side owns the wire
  assign pin_i = pin_oe ? pin_o : ext_lvl;
endmodule // tcio_pin_model

// File: dv/testbench.sv
// Testbench for the timer channel pin function and request control
`timescale 1ns/10ps
module testbench
  import tcio_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [TCIO_AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic a_o, a_oe, a_i, b_o, b_oe, b_i, lvl_a, lvl_b;
  logic irq_a, irq_b, irq_o, irq_u, conv;
  logic [32:0] exp_q[$];
  int miscompares, checked, conv_n;
  logic [31:0] rng = 32'h00011dd8;
  // Compare table: oe, initial level, level after match, field
  logic [6:0] cmp [5] = '{7'h65, 7'h52, 7'h67, 7'h53, 7'h24};
  // Capture table: flag on rise, flag on fall, field
  logic [5:0] cap [3] = '{6'h28, 6'h1d, 6'h3b};
  logic [7:0] ien [6] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h20, 8'h33};

  tcio_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_a_i(a_i), .pin_a_o(a_o), .pin_a_oe(a_oe), .pin_b_i(b_i),
    .pin_b_o(b_o), .pin_b_oe(b_oe), .match_a_irq(irq_a), .match_b_irq(irq_b),
    .overflow_irq(irq_o), .underflow_irq(irq_u), .converter_start(conv));
  tcio_pin_model i_pin_a (.pin_o(a_o), .pin_oe(a_oe), .ext_lvl(lvl_a), .pin_i(a_i));
  tcio_pin_model i_pin_b (.pin_o(b_o), .pin_oe(b_oe), .ext_lvl(lvl_b), .pin_i(b_i));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ==========================================
  // Helpers
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Pready is taken at the rising edge that ends the access, before that edge's updates
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    n = 0;
    if (!wr)
      exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
    begin
      miscompares++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [17:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask

  // ==========================================
  // Watchers
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check("read", {pslverr, prdata}, exp_q.pop_front());
    if (conv === 1'b1)
      conv_n++;
  end

  initial
  begin
    repeat (50000) @(posedge pclk);
    miscompares++;
    finish_test();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    logic [15:0] v;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    lvl_a = 1'b0;
    lvl_b = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(TCIO_ADDR_PFC, 32'h0);
    rd(TCIO_ADDR_IEN, 32'h0);
    apb(1'b0, 18'h00000, 32'h0, {1'b1, 32'h0});
    wr(TCIO_ADDR_IEN, xs() | 32'h000000ff);
    rd(TCIO_ADDR_IEN, 32'h000000b3);
    wr(TCIO_ADDR_IEN, 32'h00000080);
    wr(TCIO_ADDR_GRA, 32'h00000010);
    wr(TCIO_ADDR_GRB, 32'h00000010);
    $display("test registers done");
    foreach (cmp[i])
    begin
      wr(TCIO_ADDR_CTL, 32'h0);
      wr(TCIO_ADDR_CNT, 32'h0);
      wr(TCIO_ADDR_PFC, {24'h0, cmp[i][3:0], cmp[i][3:0]});
      cyc(3);
      check("oe a", 33'(a_oe), 33'(cmp[i][6]));
      check("oe b", 33'(b_oe), 33'(cmp[i][6]));
      if (cmp[i][6])
      begin
        check("init a", 33'(a_o), 33'(cmp[i][5]));
        check("init b", 33'(b_o), 33'(cmp[i][5]));
      end
      wr(TCIO_ADDR_CTL, 32'h1);
      cyc(30);
      wr(TCIO_ADDR_CTL, 32'h0);
      if (cmp[i][6])
      begin
        check("match a", 33'(a_o), 33'(cmp[i][4]));
        check("match b", 33'(b_o), 33'(cmp[i][4]));
      end
    end
    check("starts", 33'(conv_n), 33'h5);
    rd(TCIO_ADDR_STAT, 32'h3);
    $display("test compare done");
    wr(TCIO_ADDR_CNT, 32'h0000fffe);
    wr(TCIO_ADDR_CTL, 32'h1);
    cyc(4);
    wr(TCIO_ADDR_CTL, 32'h0);
    wr(TCIO_ADDR_CNT, 32'h1);
    wr(TCIO_ADDR_IEN, 32'h00000020);
    wr(TCIO_ADDR_CTL, 32'h3);
    cyc(4);
    wr(TCIO_ADDR_CTL, 32'h0);
    rd(TCIO_ADDR_STAT, 32'h33);
    foreach (ien[i])
    begin
      wr(TCIO_ADDR_IEN, {24'h0, ien[i]});
      cyc(3);
      check("irq", 33'({irq_u, irq_o, irq_b, irq_a}),
            33'({ien[i][5], ien[i][4], ien[i][1], ien[i][0]}));
    end
    wr(TCIO_ADDR_IEN, 32'h0);
    $display("test requests done");
    foreach (cap[i])
    begin
      wr(TCIO_ADDR_PFC, {24'h0, cap[i][3:0], cap[i][3:0]});
      cyc(8);
      v = 16'(xs());
      wr(TCIO_ADDR_CNT, {16'h0, v});
      wr(TCIO_ADDR_STAT, 32'h0);
      wr(TCIO_ADDR_GRA, 32'h0000ffff);
      wr(TCIO_ADDR_GRB, 32'h0000ffff);
      check("cap oe", 33'({a_oe, b_oe}), 33'h0);
      lvl_a <= 1'b1;
      lvl_b <= 1'b1;
      cyc(8);
      rd(TCIO_ADDR_STAT, {30'h0, cap[i][5], cap[i][5]});
      rd(TCIO_ADDR_GRA, cap[i][5] ? {16'h0, v} : 32'h0000ffff);
      rd(TCIO_ADDR_GRB, cap[i][5] ? {16'h0, v} : 32'h0000ffff);
      wr(TCIO_ADDR_STAT, 32'h0);
      wr(TCIO_ADDR_GRA, 32'h0000ffff);
      wr(TCIO_ADDR_GRB, 32'h0000ffff);
      lvl_a <= 1'b0;
      lvl_b <= 1'b0;
      cyc(8);
      rd(TCIO_ADDR_STAT, {30'h0, cap[i][4], cap[i][4]});
      rd(TCIO_ADDR_GRA, cap[i][4] ? {16'h0, v} : 32'h0000ffff);
      rd(TCIO_ADDR_GRB, cap[i][4] ? {16'h0, v} : 32'h0000ffff);
    end
    check("starts off", 33'(conv_n), 33'h5);
    $display("test capture done");
    presetn <= 1'b0;
    cyc(3);
    presetn <= 1'b1;
    rd(TCIO_ADDR_STAT, 32'h0);
    rd(TCIO_ADDR_GRA, 32'h0000ffff);
    check("reset pins", 33'({a_oe, b_oe, irq_a, conv}), 33'h0);
    $display("test reset done");
    finish_test();
  end
endmodule // testbench
